// file: pkg/flash_seq_pkg.sv
// Constants, enumerations and register map for the flash command sequencer.
// Assumes a 20 MHz system clock and a byte-wide, 64-kbyte flash array.
package flash_seq_pkg;

   // ----------------------------------------------------------------
   // Clock and operation timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 50;                 // 20 MHz clock
   localparam int PROG_TIME_NS   = 40000;              // Byte / security program, 40 us
   localparam int ERASE_TIME_US  = 30000;              // Sector or chip erase, 30 ms
   localparam int PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int ERASE_CYCLES   = (ERASE_TIME_US * 1000) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Array geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W         = 16;                 // Byte address width
   localparam int SECTOR_BYTES   = 4096;               // One sector
   localparam int SECTOR_LSB     = 12;                 // Sector select starts here
   localparam int ARRAY_BYTES    = 65536;              // Whole array
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // ----------------------------------------------------------------
   // Command sequence addresses (low 12 bits, security address all 16 bits) and data
   // ----------------------------------------------------------------
   localparam logic [11:0] UNLOCK_A1   = 12'h555;
   localparam logic [11:0] UNLOCK_A2   = 12'haaa;
   localparam logic [7:0]  UNLOCK_D1   = 8'haa;
   localparam logic [7:0]  UNLOCK_D2   = 8'h55;
   localparam logic [7:0]  CMD_D_PROG  = 8'ha0;
   localparam logic [7:0]  CMD_D_ERASE = 8'h80;
   localparam logic [7:0]  CMD_D_SECUR = 8'ha5;
   localparam logic [7:0]  CMD_D_CHIP  = 8'h10;
   localparam logic [7:0]  CMD_D_SECT  = 8'h30;
   localparam logic [15:0] SECUR_ADDR  = 16'hff7f;
   localparam logic [7:0]  SECUR_DATA  = 8'h00;

   // ----------------------------------------------------------------
   // APB register map
   // ----------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS    = 12'h000;     // flash_control_reg
   localparam logic [11:0] STAT_OFS    = 12'h004;     // Status
   localparam int          MODE_LSB    = 4;           // cmd_sequence_mode_field [7:4]
   localparam int          BANK_BIT    = 3;           // Bank select
   localparam logic [3:0]  MODE_ENABLE = 4'h3;
   localparam logic [3:0]  MODE_DISABLE= 4'hc;
   localparam logic [3:0]  MODE_RESET  = 4'hc;
   localparam int          ST_BUSY_BIT = 0;
   localparam int          ST_SECU_BIT = 1;
   localparam int          ST_TOGG_BIT = 2;
   localparam int          PROGRESS_BIT= 6;           // progress_toggle_bit position

   // Accepted command kinds
   typedef enum logic [1:0] {
      CMD_PROG,
      CMD_SECTOR,
      CMD_CHIP,
      CMD_SECURE
   } cmd_kind_e;

endpackage

// file: src/flash_cmd_decoder.sv
// Unlock-sequence decoder for flash program / erase / security commands.
// Assumes wr_en is already gated by the enable code and by the idle engine.
`timescale 1ns/10ps
module flash_cmd_decoder
   import flash_seq_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire logic                 wr_en,
   input  wire logic [ADDR_W-1:0]    wr_addr,
   input  wire logic [7:0]           wr_data,
   output logic                      cmd_start,
   output flash_seq_pkg::cmd_kind_e  cmd_kind,
   output logic [ADDR_W-1:0]         cmd_addr,
   output logic [7:0]                cmd_data
);
   import flash_seq_pkg::*;

   // ----------------------------------------------------------------
   // Sequence states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_U1, ST_U2, ST_PROG, ST_SECUR, ST_E1, ST_E2, ST_E3
   } dec_state_e;

   dec_state_e state_r;          // Current step
   dec_state_e state_nxt;        // Next step
   logic       start_nxt;        // Sequence completes this write
   cmd_kind_e  kind_nxt;         // Kind of the completed sequence

   // Step match terms
   wire logic is_a1 = (wr_addr[11:0] == UNLOCK_A1);
   wire logic is_a2 = (wr_addr[11:0] == UNLOCK_A2);

   // ----------------------------------------------------------------
   // Next step
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      start_nxt = 1'b0;
      kind_nxt  = CMD_PROG;
      if (wr_en) begin
         // Any write off the expected path drops back to idle
         state_nxt = ST_IDLE;
         unique case (state_r)
            ST_IDLE: begin
               if (is_a1 && wr_data == UNLOCK_D1) state_nxt = ST_U1;
            end
            ST_U1: begin
               if (is_a2 && wr_data == UNLOCK_D2) state_nxt = ST_U2;
            end
            ST_U2: begin
               // Third write picks program, erase or security
               if (is_a1 && wr_data == CMD_D_PROG) state_nxt = ST_PROG;
               else if (is_a1 && wr_data == CMD_D_ERASE) state_nxt = ST_E1;
               else if (is_a1 && wr_data == CMD_D_SECUR) state_nxt = ST_SECUR;
            end
            ST_PROG: begin
               // Fourth write carries target byte
               start_nxt = 1'b1;
               kind_nxt  = CMD_PROG;
            end
            ST_SECUR: begin
               if (wr_addr == SECUR_ADDR && wr_data == SECUR_DATA) begin
                  start_nxt = 1'b1;
                  kind_nxt  = CMD_SECURE;
               end
            end
            ST_E1: begin
               if (is_a1 && wr_data == UNLOCK_D1) state_nxt = ST_E2;
            end
            ST_E2: begin
               if (is_a2 && wr_data == UNLOCK_D2) state_nxt = ST_E3;
            end
            ST_E3: begin
               // Sixth write: chip erase at fixed address
               if (is_a1 && wr_data == CMD_D_CHIP) begin
                  start_nxt = 1'b1;
                  kind_nxt  = CMD_CHIP;
               end else if (wr_data == CMD_D_SECT) begin
                  // Sector from upper address bits
                  start_nxt = 1'b1;
                  kind_nxt  = CMD_SECTOR;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Step register and registered start pulse
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= ST_IDLE;
         cmd_start <= 1'b0;
         cmd_kind  <= CMD_PROG;
         cmd_addr  <= '0;
         cmd_data  <= 8'h00;
      end else begin
         state_r   <= state_nxt;
         cmd_start <= start_nxt;
         if (start_nxt) begin
            cmd_kind <= kind_nxt;
            cmd_addr <= wr_addr;
            cmd_data <= wr_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_stray_write_idle: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && state_r == ST_U1 && !(is_a2 && wr_data == UNLOCK_D2)) |=> (state_r == ST_IDLE && !cmd_start))
      else $error("stray write did not return decoder to idle");

endmodule

// file: src/flash_program_erase_control.sv
// Flash program / erase sequencer with APB control registers and a byte port to the array.
// Assumes the CPU runs its control program from RAM or boot ROM, not from this array.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps

module flash_program_erase_control
   import flash_seq_pkg::*;
#(
   parameter int ERASE_CNT = flash_seq_pkg::ERASE_CYCLES   // Erase duration in clocks
)(
   input  wire logic                clock,
   input  wire logic                rstn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   // Byte port to the array
   input  wire logic                mem_req,
   input  wire logic                mem_we,
   input  wire logic                mem_fetch,
   input  wire logic [ADDR_W-1:0]   mem_addr,
   input  wire logic [7:0]          mem_wdata,
   output logic                     mem_ack,
   output logic [7:0]               mem_rdata,
   output logic                     mem_fault,
   // System
   input  wire logic                serial_boot,
   output logic                     flash_busy,
   output logic                     watchdog_hold
);
   import flash_seq_pkg::*;

   localparam logic [19:0] PROG_LOAD  = 20'(PROG_CYCLES - 1);
   localparam logic [19:0] ERASE_LOAD = 20'(ERASE_CNT - 1);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_r;             // First release stage
   logic rst_n_r;                // Released reset used everywhere

   // Async assert, clocked release through two flops
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]        arr [ARRAY_BYTES];   // The array itself
   logic [3:0]        mode_r;              // cmd_sequence_mode_field
   logic              bank_r;              // Bank select
   logic              busy_r;              // Operation running
   cmd_kind_e         op_kind_r;           // Running operation
   logic [19:0]       timer_r;             // Remaining operation time
   logic [ADDR_W-1:0] walk_ptr_r;          // Next byte to erase
   logic [16:0]       walk_left_r;         // Bytes still to erase
   logic              toggle_r;            // Next progress_toggle_bit value
   logic              secure_r;            // Security programmed
   logic              first_poll_r;        // No poll read yet since start

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire logic apb_acc   = psel & penable & ~pready;          // Answer next edge
   wire logic apb_done  = psel & penable & pready;           // Transfer ends here
   wire logic hit_ctrl  = (paddr == CTRL_OFS);
   wire logic hit_stat  = (paddr == STAT_OFS);
   wire logic ctrl_wr   = apb_done & pwrite & hit_ctrl & pstrb[0];
   wire logic mode_en   = (mode_r == MODE_ENABLE);
   wire logic rd_take   = mem_req & ~mem_we & ~mem_fetch;
   wire logic fe_take   = mem_req & ~mem_we & mem_fetch;
   wire logic wr_take   = mem_req & mem_we;

   // Gate command writes by enable code and idle engine
   wire logic seq_wr    = wr_take & mode_en & ~busy_r;

   // Bank 0 in serial boot folds the upper half down
   wire logic [ADDR_W-1:0] eff_addr =
      {mem_addr[ADDR_W-1] & ~(serial_boot & ~bank_r), mem_addr[ADDR_W-2:0]};

   wire logic [31:0] stat_word = {29'h0, toggle_r, secure_r, busy_r};
   wire logic [31:0] ctrl_word = {24'h0, mode_r, bank_r, 3'h0};
   wire logic [31:0] rd_word   = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0);

   // Status byte returned instead of array data while busy
   wire logic [7:0]  poll_byte = 8'(toggle_r) << PROGRESS_BIT;

   // ----------------------------------------------------------------
   // Command decoder
   // ----------------------------------------------------------------
   logic              cmd_start;           // Sequence accepted
   cmd_kind_e         cmd_kind;            // Which one
   logic [ADDR_W-1:0] cmd_addr;            // Target / sector address
   logic [7:0]        cmd_data;            // Target byte

   flash_cmd_decoder u_dec (
      .clock     (clock),
      .rst_n     (rst_n_r),
      .wr_en     (seq_wr),
      .wr_addr   (eff_addr),
      .wr_data   (mem_wdata),
      .cmd_start (cmd_start),
      .cmd_kind  (cmd_kind),
      .cmd_addr  (cmd_addr),
      .cmd_data  (cmd_data)
   );

   // Engine terms
   wire logic erasing  = busy_r & (walk_left_r != 17'h0);
   wire logic op_done  = busy_r & (timer_r == 20'h0) & ~erasing;
   wire logic prog_wr  = cmd_start & (cmd_kind == CMD_PROG);

   // ----------------------------------------------------------------
   // APB slave: one wait state, defined answer to unmapped offsets
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_acc;
         pslverr <= apb_acc & ~(hit_ctrl | hit_stat);
         if (apb_acc) begin
            prdata <= pwrite ? 32'h0 : rd_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mode_r <= MODE_RESET;
         bank_r <= 1'b0;
      end else if (ctrl_wr) begin
         // Disable code closes the decoder input
         mode_r <= pwdata[MODE_LSB +: 4];
         bank_r <= pwdata[BANK_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Operation engine
   // ----------------------------------------------------------------
   // Timer and walker run together; done only when both are spent
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         busy_r      <= 1'b0;
         op_kind_r   <= CMD_PROG;
         timer_r     <= 20'h0;
         walk_ptr_r  <= '0;
         walk_left_r <= 17'h0;
         secure_r    <= 1'b0;
      end else if (cmd_start) begin
         busy_r    <= 1'b1;
         op_kind_r <= cmd_kind;
         unique case (cmd_kind)
            CMD_PROG, CMD_SECURE: begin
               timer_r     <= PROG_LOAD;
               walk_left_r <= 17'h0;
            end
            CMD_SECTOR: begin
               // One aligned 4-kbyte sector
               timer_r     <= ERASE_LOAD;
               walk_ptr_r  <= {cmd_addr[ADDR_W-1:SECTOR_LSB], 12'h0};
               walk_left_r <= 17'(SECTOR_BYTES);
            end
            CMD_CHIP: begin
               // Whole array, clears security too
               timer_r     <= ERASE_LOAD;
               walk_ptr_r  <= '0;
               walk_left_r <= 17'(ARRAY_BYTES);
               secure_r    <= 1'b0;
            end
         endcase
      end else if (busy_r) begin
         if (timer_r != 20'h0) timer_r <= timer_r - 20'h1;
         if (erasing) begin
            walk_ptr_r  <= walk_ptr_r + 16'h1;
            walk_left_r <= walk_left_r - 17'h1;
         end
         if (op_done) begin
            busy_r <= 1'b0;
            if (op_kind_r == CMD_SECURE) secure_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Array writes: one byte per clock, no reset on storage
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (prog_wr) begin
         arr[cmd_addr] <= cmd_data;
      end else if (erasing) begin
         arr[walk_ptr_r] <= ERASED_BYTE;
      end
   end

   // ----------------------------------------------------------------
   // Toggle bit: preset to one at start, flips per poll read
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         toggle_r     <= 1'b0;
         first_poll_r <= 1'b0;
      end else if (cmd_start) begin
         toggle_r     <= 1'b1;
         first_poll_r <= 1'b1;
      end else if (rd_take & busy_r) begin
         toggle_r     <= ~toggle_r;
         first_poll_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Byte port answer, one clock after the request
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mem_ack   <= 1'b0;
         mem_rdata <= 8'h00;
         mem_fault <= 1'b0;
      end else begin
         mem_ack   <= mem_req;
         // Fetches refused across the whole array while busy
         mem_fault <= fe_take & busy_r;
         if (busy_r & (rd_take | fe_take)) begin
            mem_rdata <= fe_take ? ERASED_BYTE : poll_byte;
         end else if (rd_take | fe_take) begin
            mem_rdata <= arr[eff_addr];
         end
      end
   end

   // ----------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         flash_busy    <= 1'b0;
         watchdog_hold <= 1'b0;
      end else begin
         flash_busy    <= busy_r | cmd_start;
         // Loader mode keeps the watchdog off
         watchdog_hold <= serial_boot;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n_r);

   chk_first_poll_one: assert property (
      (rd_take && busy_r && first_poll_r && !cmd_start) |=> mem_rdata[PROGRESS_BIT])
      else $error("first poll read did not return one");
   // Polls spaced as a CPU issues them: two idle clocks between reads
   chk_poll_flips: assert property (
      (rd_take && busy_r && !cmd_start) ##1 (!mem_req) [*2] ##1 (rd_take && busy_r && !cmd_start)
      |=> mem_rdata[PROGRESS_BIT] != $past(mem_rdata[PROGRESS_BIT], 3))
      else $error("progress bit did not flip between polls");
   chk_array_hidden: assert property (
      (rd_take && busy_r) |=> (mem_rdata[7] == 1'b0 && mem_rdata[5:0] == 6'h0))
      else $error("array data visible while busy");
   chk_fetch_refused: assert property (
      (fe_take && busy_r) |=> (mem_fault && mem_ack))
      else $error("fetch not refused while busy");
   chk_needs_enable: assert property (
      cmd_start |-> $past(mode_r == MODE_ENABLE, 1))
      else $error("command accepted without enable code");
   chk_disable_blocks: assert property (
      (mode_r == MODE_DISABLE) [*2] |-> !cmd_start)
      else $error("command accepted while disabled");
   chk_sector_span: assert property (
      (cmd_start && cmd_kind == CMD_SECTOR) |=> (walk_left_r == 17'(SECTOR_BYTES) && walk_ptr_r[11:0] == 12'h0))
      else $error("sector erase span wrong");
   chk_prog_time: assert property (
      (cmd_start && cmd_kind == CMD_PROG) |=> busy_r [*8] ##1 (timer_r == PROG_LOAD - 20'd8))
      else $error("program timer not running");
   chk_done_stable: assert property (
      (rd_take && !busy_r && !cmd_start && !prog_wr)
      |=> (mem_ack && !mem_fault && mem_rdata == $past(arr[eff_addr])))
      else $error("idle read did not return stored byte");

   cov_prog: cover property (cmd_start && cmd_kind == CMD_PROG);
   cov_sector: cover property (cmd_start && cmd_kind == CMD_SECTOR);
   cov_chip_done: cover property (op_done && op_kind_r == CMD_CHIP);
   cov_secure: cover property (op_done && op_kind_r == CMD_SECURE);

endmodule

// file: testbench/cpu_model.sv
// Byte-port model of the CPU running its control program out of RAM.
// Assumes mem_ack comes one clock after each taken mem_req.
`timescale 1ns/10ps
module cpu_model(
   input  wire logic        clock,
   input  wire logic        mem_ack,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_fault,
   output logic             mem_req   = 1'b0,
   output logic             mem_we    = 1'b0,
   output logic             mem_fetch = 1'b0,
   output logic [15:0]      mem_addr  = 16'h0000,
   output logic [7:0]       mem_wdata = 8'h00
);
   // ----------------------------------------
   // One byte access
   // ----------------------------------------
   // Runs from RAM with interrupts off; fe set drives a fetch from the array
   task automatic acc(input logic we, fe, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic f);
      int n;
      @(posedge clock);
      mem_req <= 1'b1; mem_we <= we; mem_fetch <= fe; mem_addr <= a; mem_wdata <= d;
      @(posedge clock);
      mem_req <= 1'b0;
      mem_addr <= ~a;  // Released lines do not keep the old value
      mem_wdata <= ~d;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (mem_ack !== 1'b1 && n < 4);
      q = (mem_ack === 1'b1) ? mem_rdata : 8'hxx;  // No answer never matches
      f = (mem_ack === 1'b1) ? mem_fault : 1'bx;
   endtask
endmodule

// file: testbench/flash_program_erase_control_tb.sv
// Bench for the flash sequencer: APB master, CPU byte-port model, scenarios.
// Assumes the array is chip-erased before any data is read back.
`timescale 1ns/10ps
module flash_program_erase_control_tb;
   import flash_seq_pkg::*;
   logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, serial_boot = 0, f;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [3:0]  pstrb = 4'hf;
   logic [7:0]  q, p;
   wire pready, pslverr, mem_req, mem_we, mem_fetch, mem_ack, mem_fault, flash_busy, watchdog_hold;
   wire [31:0] prdata;
   wire [15:0] mem_addr;
   wire [7:0]  mem_wdata, mem_rdata;
   int num_errors = 0, num_checks = 0;
   always #25 clock = ~clock;
   // Short erase time: the byte walk then sets chip erase length
   flash_program_erase_control #(.ERASE_CNT(5000)) u_flash_program_erase_control(.clock, .rstn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .mem_req,
      .mem_we, .mem_fetch, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .mem_fault,
      .serial_boot, .flash_busy, .watchdog_hold);
   cpu_model u_cpu_model(.clock, .mem_ack, .mem_rdata, .mem_fault, .mem_req, .mem_we,
      .mem_fetch, .mem_addr, .mem_wdata);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] g, x);
      num_checks++;
      if (g !== x) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 8);
      rd = (pready === 1'b1) ? prdata : 'x;
      f = (pready === 1'b1) ? pslverr : 1'bx;
      psel <= 0; penable <= 0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      u_cpu_model.acc(1'b1, 1'b0, a, d, q, f);
   endtask
   task automatic rdb(input logic [15:0] a);
      u_cpu_model.acc(1'b0, 1'b0, a, 8'h00, q, f);
   endtask
   task automatic seq6(input logic [7:0] last);
      wr(16'hf555, 8'haa); wr(16'hfaaa, 8'h55); wr(16'hf555, 8'h80);
      wr(16'hf555, 8'haa); wr(16'hfaaa, 8'h55); wr(16'hf555, last);
   endtask
   task automatic prog(input logic [15:0] a, input logic [7:0] d);
      wr(16'hf555, 8'haa); wr(16'hfaaa, 8'h55); wr(16'hf555, 8'ha0); wr(a, d);
   endtask
   // Read one address until two reads agree
   task automatic poll(input logic [15:0] a);
      int n;
      n = 0;
      rdb(a);
      do begin
         p = q;
         rdb(a);
         n++;
      end while (q !== p && n < 40000);
      chk(q, p);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      apb(0, CTRL_OFS, 0); chk(rd, 32'hc0);
      apb(0, 12'h008, 0); chk(f, 1);
      apb(0, STAT_OFS, 0); chk(rd[0], 0);
   endtask
   task automatic t_locked;
      seq6(CMD_D_CHIP); repeat (3) @(posedge clock); chk(flash_busy, 0);
   endtask
   task automatic t_erase;
      apb(1, CTRL_OFS, 32'h30); seq6(CMD_D_CHIP); repeat (2) @(posedge clock);
      chk(flash_busy, 1);
      rdb(16'h1234); chk(q, 8'h40);
      rdb(16'h1234); chk(q, 8'h00);
      u_cpu_model.acc(1'b0, 1'b1, 16'h2000, 8'h00, q, f); chk({f, q}, 9'h1ff);
      poll(16'h1234); chk(flash_busy, 0);
      rdb(16'hffff); chk(q, 8'hff);
   endtask
   task automatic t_prog;
      wr(16'hf555, 8'haa); wr(16'hfaaa, 8'h11); wr(16'hfaaa, 8'h55); wr(16'hf555, 8'ha0);
      wr(16'hf000, 8'h3f); repeat (3) @(posedge clock); chk(flash_busy, 0);
      prog(16'hf000, 8'h3f); rdb(16'hf000); chk(q, 8'h40);
      poll(16'hf000); chk(q, 8'h3f);
      rdb(16'hf001); chk(q, 8'hff);
   endtask
   task automatic t_sect;
      prog(16'he000, 8'h5a); poll(16'he000); chk(q, 8'h5a);
      seq6(CMD_D_SECT); poll(16'hf000); chk(q, 8'hff);
      rdb(16'he000); chk(q, 8'h5a);
   endtask
   task automatic t_sec;
      wr(16'hf555, 8'haa); wr(16'hfaaa, 8'h55); wr(16'hf555, 8'ha5); wr(16'hff7f, 8'h00);
      rdb(16'hf000); chk(q, 8'h40);
      poll(16'hf000); apb(0, STAT_OFS, 0); chk(rd[1:0], 2'b10);
   endtask
   // Loader mode, bank 0: upper half folds onto the lower half
   task automatic t_bank;
      serial_boot <= 1; apb(1, CTRL_OFS, 32'h30);
      prog(16'hf010, 8'hc3); poll(16'hf010); chk(q, 8'hc3);
      serial_boot <= 0; rdb(16'h7010); chk(q, 8'hc3);
      chk(watchdog_hold, 0);
      rdb(16'hf010); chk(q, 8'hff);
   endtask
   task automatic t_off;
      apb(1, CTRL_OFS, 32'hc0); prog(16'hf001, 8'h00); repeat (3) @(posedge clock);
      chk(flash_busy, 0);
      rdb(16'hf001); chk(q, 8'hff);
      serial_boot <= 1; repeat (3) @(posedge clock); chk(watchdog_hold, 1);
   endtask
   // ----------------------------------------
   // Verdict and run control
   // ----------------------------------------
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rstn <= 1;
      repeat (5) @(posedge clock);
      t_regs; t_locked; t_erase; t_prog; t_sect; t_sec; t_bank; t_off;
      summarize;
   end
   // Chip erase walk alone takes about 3.3 ms, the rest about 0.4 ms
   initial begin
      #4500000;
      num_errors++;
      summarize;
   end
endmodule
